// ---- core/mul_unit.sv ----
// Unsigned 8x8 multiply datapath with product register pair
// Functional notes
// - literal multiply is W times the 8-bit instruction literal.
// - full 16-bit product is written, never truncated.
// - high byte to product high, low byte to low; W untouched.
// - no status flag changes; zero, carry, overflow never reported.
// - register multiply uses W times addressed byte; sources unchanged.
// - register multiply encoded 0000 001a then 8-bit file address.
// - bank-access bit 0 resolves the address in the access bank.
// - bank-access bit 1 prefixes the bank select register number.
// - extended set with a=0 and f<=5Fh uses indexed literal offset.
`include "mul_unit_cfg.svh"
module mul_unit (
	input wire logic clk,
	input wire logic srst,
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire logic [7:0] workReg,
	input wire logic [3:0] bankSelect,
	input wire logic extEnable,
	input wire logic [7:0] indexBase,
	output logic [11:0] dataAddr,
	output logic dataRead,
	input wire logic [7:0] dataIn,
	output logic [7:0] productHigh,
	output logic [7:0] productLow,
	output logic productWrite,
	output logic indexedMode,
	output mul_unit_pkg::phase_e phase
);
	import mul_unit_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		phase_e ph;
		mulop_e op;
		logic [7:0] opA;
		logic [7:0] opB;
		logic [15:0] prod;
		logic [7:0] hi;
		logic [7:0] lo;
		logic wr;
	} state_s;

	state_s s_q, s_d;
	mulop_e opDec;
	logic [7:0] lowByte;
	logic bankBit;

	// ----------------------------------------
	// Decoding and arithmetic
	// ----------------------------------------
	function automatic logic [7:0] lowField(input logic [15:0] w);
		return w[`MUL_FILE_MSB:`MUL_FILE_LSB];
	endfunction

	function automatic mulop_e decode(input logic [15:0] w);
		if (w[`MUL_OPC_MSB:`MUL_OPC_LIT_LSB] == `MUL_OPC_LIT)
			return OP_LIT;
		if (w[`MUL_OPC_MSB:`MUL_OPC_REG_LSB] == `MUL_OPC_REG)
			return OP_REG;
		return OP_NONE;
	endfunction

	// Both bytes are widened first, so no carry out of bit 7 is lost
	function automatic logic [15:0] product16(input logic [7:0] a,
		input logic [7:0] b);
		logic [15:0] wideA;
		logic [15:0] wideB;
		wideA = 16'(a);
		wideB = 16'(b);
		return wideA * wideB;
	endfunction

	// Literal and file address share the low byte of the word
	assign lowByte = lowField(instrWord);
	assign bankBit = instrWord[`MUL_BANK_BIT];
	assign opDec = instrValid ? decode(instrWord) : OP_NONE;

	mul_addr_resolve u_resolve (
		.bankAccess(bankBit),
		.fileAddr(lowByte),
		.bankSelect(bankSelect),
		.extEnable(extEnable),
		.indexBase(indexBase),
		.dataAddr(dataAddr),
		.indexedMode(indexedMode)
	);

	// ----------------------------------------
	// Quarter sequencing
	// ----------------------------------------
	// Instruction word must stay stable Q1..Q2 so the operand read matches.
	always_comb begin
		s_d = s_q;
		s_d.wr = 1'b0;
		if (srst) begin
			// Reset wins over a quarter in flight; a cut multiply is lost
			s_d = '0;
			s_d.ph = phase_e'(`MUL_PHASE_RESET);
			s_d.hi = `MUL_PROD_RESET;
			s_d.lo = `MUL_PROD_RESET;
		end else begin
			unique case (s_q.ph)
				PH_Q1: begin
					s_d.op = opDec;
					s_d.ph = PH_Q2;
				end
				PH_Q2: begin
					s_d.opA = workReg;
					if (s_q.op == OP_LIT) begin
						s_d.opB = lowByte;
					end else begin
						s_d.opB = dataIn;
					end
					s_d.ph = PH_Q3;
				end
				PH_Q3: begin
					s_d.prod = product16(s_q.opA, s_q.opB);
					s_d.ph = PH_Q4;
				end
				PH_Q4: begin
					if (s_q.op != OP_NONE) begin
						{s_d.hi, s_d.lo} = s_q.prod;
						s_d.wr = 1'b1;
					end
					s_d.op = OP_NONE;
					s_d.ph = PH_Q1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// The operand read strobe, dataAddr and indexedMode are combinational; no flag outputs exist.
	assign dataRead = (s_q.ph == PH_Q2) && (s_q.op == OP_REG);
	assign productHigh = s_q.hi;
	assign productLow = s_q.lo;
	assign productWrite = s_q.wr;
	assign phase = s_q.ph;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// Operands settle at the Q2 edge, two samples back from the write
	chk_product_value: assert property (
		productWrite |-> {productHigh, productLow}
			== product16($past(s_q.opA, 2), $past(s_q.opB, 2)))
		else $error("product pair does not match operands");
	chk_product_split: assert property (
		productWrite |-> {productHigh, productLow} == $past(s_q.prod))
		else $error("product bytes swapped or shifted");
	chk_write_phase: assert property (
		productWrite |-> phase == PH_Q1 && $past(phase) == PH_Q4)
		else $error("product written outside Q4");
	chk_write_pulse: assert property (
		productWrite |=> !productWrite)
		else $error("product write longer than one cycle");
	chk_phase_onehot: assert property ($onehot(phase))
		else $error("quarter code not one-hot");
	chk_phase_wrap: assert property (
		phase == PH_Q4 |=> phase == PH_Q1)
		else $error("quarter ring did not wrap");
	chk_lit_operand: assert property (
		(phase == PH_Q2 && s_q.op == OP_LIT) |=> s_q.opB == $past(lowByte))
		else $error("literal operand not taken");
	chk_lit_no_read: assert property (
		(phase == PH_Q2 && s_q.op != OP_REG) |-> !dataRead)
		else $error("data read outside a register multiply");
	chk_reg_operand: assert property (
		(phase == PH_Q2 && s_q.op == OP_REG) |=> s_q.opB == $past(dataIn))
		else $error("file operand not taken");
	chk_sources_kept: assert property (
		phase == PH_Q3 |=> $stable(s_q.opA) && $stable(s_q.opB))
		else $error("operand latches moved during compute");
	// Needs reset held two edges, else the clear itself looks like a change
	chk_pair_hold: assert property (
		!productWrite |-> $stable(productHigh) && $stable(productLow))
		else $error("product pair changed without write");
	chk_lit_decode: assert property (
		(phase == PH_Q1 && instrValid
			&& instrWord[`MUL_OPC_MSB:`MUL_OPC_LIT_LSB] == `MUL_OPC_LIT)
		|-> ##4 productWrite)
		else $error("literal multiply not decoded");
	chk_refused_op: assert property (
		(phase == PH_Q1 && opDec == OP_NONE) |-> ##4 !productWrite)
		else $error("product written for a refused word");
	chk_reg_seq: assert property (
		(phase == PH_Q1 && instrValid
			&& instrWord[`MUL_OPC_MSB:`MUL_OPC_REG_LSB] == `MUL_OPC_REG)
		|=> dataRead ##3 productWrite)
		else $error("register multiply sequence wrong");
	chk_bank_addr: assert property (
		bankBit |-> dataAddr == {bankSelect, lowByte})
		else $error("banked address wrong");
	chk_indexed: assert property (
		(!bankBit && extEnable && lowByte <= `MUL_ILO_LIMIT) |-> indexedMode)
		else $error("indexed mode not selected");
	chk_access_low: assert property (
		(!bankBit && !indexedMode && lowByte < `MUL_ACCESS_SPLIT)
		|-> dataAddr == {`MUL_ACCESS_LOW_BASE, lowByte})
		else $error("access bank address wrong");
	chk_access_high: assert property (
		(!bankBit && !indexedMode && lowByte >= `MUL_ACCESS_SPLIT)
		|-> dataAddr == {`MUL_ACCESS_SFR_BASE, lowByte})
		else $error("upper access bank address wrong");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	cov_lit: cover property (phase == PH_Q2 && s_q.op == OP_LIT);
	cov_reg: cover property (dataRead);
	cov_idx: cover property (dataRead && indexedMode);
	cov_zero: cover property (productWrite && {productHigh, productLow} == '0);
	cov_chain: cover property (productWrite && opDec != OP_NONE);
endmodule

// ---- core/mul_unit_cfg.svh ----
// Constants for the unsigned 8x8 multiply unit
`ifndef MUL_UNIT_CFG_SVH
`define MUL_UNIT_CFG_SVH
`define MUL_OPC_LIT 8'h0D
`define MUL_OPC_REG 7'h01
`define MUL_ILO_LIMIT 8'h5F
`define MUL_ACCESS_SFR_BASE 4'hF
`define MUL_ACCESS_SPLIT 8'h80
`define MUL_PROD_RESET 8'h00
`define MUL_PHASE_RESET 4'h1
`define MUL_ACCESS_LOW_BASE 4'h0
`define MUL_OPC_MSB 15
`define MUL_OPC_LIT_LSB 8
`define MUL_OPC_REG_LSB 9
`define MUL_BANK_BIT 8
`define MUL_FILE_MSB 7
`define MUL_FILE_LSB 0
`endif

// ---- core/mul_unit_pkg.sv ----
// Types shared by the multiply unit
package mul_unit_pkg;
	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} phase_e;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_LIT = 2'b01,
		OP_REG = 2'b10
	} mulop_e;
endpackage

// ---- core/mul_addr_resolve.sv ----
// File address resolution for the register-operand multiply
`include "mul_unit_cfg.svh"
module mul_addr_resolve (
	input wire logic bankAccess,
	input wire logic [7:0] fileAddr,
	input wire logic [3:0] bankSelect,
	input wire logic extEnable,
	input wire logic [7:0] indexBase,
	output logic [11:0] dataAddr,
	output logic indexedMode
);
	always_comb begin
		indexedMode = 1'b0;
		if (bankAccess) begin
			dataAddr = {bankSelect, fileAddr};
		end else if (extEnable && fileAddr <= `MUL_ILO_LIMIT) begin
			indexedMode = 1'b1;
			dataAddr = {`MUL_ACCESS_LOW_BASE, 8'(indexBase + fileAddr)};
		end else if (fileAddr < `MUL_ACCESS_SPLIT) begin
			dataAddr = {`MUL_ACCESS_LOW_BASE, fileAddr};
		end else begin
			dataAddr = {`MUL_ACCESS_SFR_BASE, fileAddr};
		end
	end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the unsigned 8x8 multiply unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import mul_unit_pkg::*;
	logic clk = 0, srst = 1, instrValid = 0, extEnable = 0;
	logic [15:0] instrWord = 0;
	logic [7:0] workReg = 0, indexBase = 0, dataIn = 0;
	logic [3:0] bankSelect = 0;
	logic [11:0] dataAddr;
	logic [7:0] productHigh, productLow;
	logic dataRead, productWrite, indexedMode;
	phase_e phase;
	int nErrors = 0, testsRun = 0, cycles = 0;
	logic rd, im, wr;
	logic [3:0] ph;
	logic [11:0] adr;
	logic [15:0] prod;
	always #10 clk = ~clk;
	mul_unit mul_unit_inst (.clk(clk), .srst(srst), .instrValid(instrValid),
		.instrWord(instrWord), .workReg(workReg), .bankSelect(bankSelect),
		.extEnable(extEnable), .indexBase(indexBase), .dataAddr(dataAddr),
		.dataRead(dataRead), .dataIn(dataIn), .productHigh(productHigh),
		.productLow(productLow), .productWrite(productWrite),
		.indexedMode(indexedMode), .phase(phase));
	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic finishTest;
		if (nErrors == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		testsRun++;
		if (got !== exp) begin
			nErrors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Cut a hang short; the whole run needs well under 200 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 400) begin
			nErrors++;
			finishTest();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Issues one instruction at Q1, samples Q2 and the cycle after Q4
	task automatic runOp(input logic [15:0] iw, input logic [7:0] w, d);
		int k;
		k = 0;
		while (phase !== PH_Q1 && k < 8) begin
			@(negedge clk);
			k++;
		end
		instrWord = iw;
		workReg = w;
		dataIn = d;
		instrValid = 1;
		@(negedge clk);
		instrValid = 0;
		rd = dataRead;
		adr = dataAddr;
		im = indexedMode;
		ph = phase;
		repeat (3) @(negedge clk);
		wr = productWrite;
		prod = {productHigh, productLow};
	endtask
	task automatic testLiteral;
		runOp(16'h0DC4, 8'hE2, 8'h00);
		chk(prod, 16'hAD08);
		chk({wr, rd}, 2'b10);
		chk(ph, PH_Q2);
		runOp(16'h0DFF, 8'hFF, 8'h00);
		chk(prod, 16'hFE01);
		runOp(16'h0D00, 8'h77, 8'h00);
		chk({wr, prod}, 17'h1_0000);
		@(negedge clk);
		chk(productWrite, 1'b0);
	endtask
	task automatic testRegister;
		bankSelect = 4'h3;
		runOp(16'h035A, 8'hC4, 8'hB5);
		chk({wr, rd}, 2'b11);
		chk(adr, 12'h35A);
		chk(prod, 16'h8A94);
		runOp(16'h0290, 8'h12, 8'h10);
		chk(adr, 12'hF90);
		chk(prod, 16'h0120);
		extEnable = 1;
		indexBase = 8'h40;
		runOp(16'h025F, 8'h02, 8'h03);
		chk({im, rd}, 2'b11);
		runOp(16'h0260, 8'h02, 8'h03);
		chk({im, adr}, 13'h0060);
		extEnable = 0;
	endtask
	task automatic testRefused;
		runOp(16'h0E55, 8'h09, 8'h09);
		chk({wr, rd}, 2'b00);
		chk(prod, 16'h0006);
	endtask
	// Mid-run reset held two edges must clear a nonzero pair
	task automatic testReset;
		srst = 1;
		repeat (2) @(negedge clk);
		srst = 0;
		chk({productWrite, productHigh, productLow}, 17'h0_0000);
		chk(phase, PH_Q1);
		runOp(16'h0D03, 8'h05, 8'h00);
		chk(prod, 16'h000F);
	endtask
	initial begin
		repeat (6) @(negedge clk);
		srst = 0;
		chk({productWrite, productHigh, productLow}, 17'h0_0000);
		testLiteral();
		testRegister();
		testRefused();
		testReset();
		finishTest();
	end
endmodule
